// ---- src/sweep_trigger_control.sv ----
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RULE1) External mode: sweep starts on selected edge
// (RULE2) Manual mode: wait for manual command
// (RULE3) Trigger output rises as sweep begins
// (RULE4) Trigger output falls when sweep completes
// (RULE5) Start/stop commands; reprogram only when idle
// (RULE6) Stop freezes frequency at current point
// (RULE7) Hold last point until next trigger, optional
// (RULE8) Host defines sweep by start, step, points
// (RULE9) Status register shows sweeping or idle
// (RULE10) Triggers during a sweep are ignored
module sweep_trigger_control
(
   input wire logic clk_i,                               // System clock
   input wire logic rst_i,                               // Sync reset, active high
   input wire logic ce_i,                                // Clock enable
   input wire logic cyc_i,                               // Wishbone cycle
   input wire logic stb_i,                               // Wishbone strobe
   input wire logic we_i,                                // Wishbone write enable
   input wire logic [sweep_pkg::ADDR_W-1:0] adr_i,       // Wishbone byte address
   input wire logic [3:0] sel_i,                         // Wishbone byte selects
   input wire logic [31:0] dat_i,                        // Wishbone write data
   output logic [31:0] dat_o,                            // Wishbone read data
   output logic ack_o,                                   // Wishbone acknowledge
   input wire logic trig_in_i,                           // External trigger input
   input wire logic point_done_i,                        // Current point measured
   output logic trig_out_o,                              // High during a sweep
   output logic [31:0] freq_o,                           // Test frequency point
   output logic sweeping_o                               // Sweep mode active
);
   import sweep_pkg::*;

   logic [3:0] ctrl_r;
   logic [31:0] fstart_r;
   logic [31:0] fstep_r;
   logic [15:0] npts_r;
   logic [15:0] idx_r;
   logic [31:0] freq_r;
   logic trig_d_r;
   logic ack_r;
   logic [31:0] dat_r;
   sweep_state_t state_r;

   logic req;
   logic wr;
   logic idle;
   logic [31:0] wdata;
   logic start_cmd;
   logic stop_cmd;
   logic manual_cmd;
   logic ext_edge;
   logic go;
   logic last_pt;
   trig_mode_t mode;

   // ==========================================================
   // Bus decode
   // ==========================================================
   // Single-cycle ack; the ack_r term stops a held request acking twice
   assign req = cyc_i & stb_i & ~ack_r;
   // Writes land on the edge where the master samples ack, never earlier
   assign wr = cyc_i & stb_i & we_i & ack_r & ce_i;
   assign idle = (state_r == ST_IDLE);
   assign mode = trig_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);

   // Byte lanes merge write data over a zero word
   always_comb
   begin
      wdata = ZERO32;
      for (int b = 0; b < 4; b++)
      begin
         if (sel_i[b])
         begin
            wdata[8*b +: 8] = dat_i[8*b +: 8];
         end
      end
   end

   // Command strobes are self-clearing pulses from writes to CMD
   assign start_cmd = wr && (adr_i == {1'b0, ADDR_CMD}) && wdata[CMD_START_BIT];
   assign stop_cmd = wr && (adr_i == {1'b0, ADDR_CMD}) && wdata[CMD_STOP_BIT];
   assign manual_cmd = wr && (adr_i == {1'b0, ADDR_CMD}) && wdata[CMD_MANUAL_BIT];

   // ==========================================================
   // Trigger detection
   // ==========================================================
   // Inputs are synchronous; one delay stage finds the edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trig_d_r <= 1'b0;
      end
      else if (ce_i)
      begin
         trig_d_r <= trig_in_i;
      end
   end

   assign ext_edge = ctrl_r[CTRL_FALL_BIT] ? (trig_d_r & ~trig_in_i)
                                           : (~trig_d_r & trig_in_i); // RULE1

   // Only consulted in ARMED, so edges mid-sweep are dropped
   always_comb
   begin
      case (mode)
         TRIG_EXT: go = ext_edge;        // RULE1
         TRIG_MANUAL: go = manual_cmd;   // RULE2
         default: go = 1'b1;
      endcase
   end

   assign last_pt = (idx_r >= npts_r - 16'h0001);

   // ==========================================================
   // Sweep sequencer
   // ==========================================================
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= ST_IDLE;
      end
      else if (ce_i)
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (start_cmd)
               begin
                  state_r <= ST_ARMED; // RULE5
               end
            end
            ST_ARMED:
            begin
               if (stop_cmd)
               begin
                  state_r <= ST_IDLE; // RULE5
               end
               else if (go)
               begin
                  state_r <= ST_SWEEP; // RULE3
               end
            end
            ST_SWEEP:
            begin
               // Triggers are not looked at here
               if (stop_cmd)
               begin
                  state_r <= ST_IDLE; // RULE5
               end
               else if (point_done_i && last_pt)
               begin
                  state_r <= ST_ARMED; // RULE4
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Frequency point
   // ==========================================================
   // Stop leaves freq_r untouched, so the point in flight is kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         idx_r <= 16'h0000;
         freq_r <= FREQ_RST;
      end
      else if (ce_i)
      begin
         if (state_r == ST_ARMED && go && !stop_cmd) // RULE10
         begin
            idx_r <= 16'h0000;
            freq_r <= fstart_r;
         end
         else if (state_r == ST_SWEEP && !stop_cmd && point_done_i) // RULE6
         begin
            if (last_pt)
            begin
               // Default hold keeps last point; option returns to start
               if (ctrl_r[CTRL_NOHOLD_BIT])
               begin
                  freq_r <= fstart_r; // RULE7
               end
            end
            else
            begin
               idx_r <= idx_r + 16'h0001;
               freq_r <= freq_r + fstep_r;
            end
         end
      end
   end

   // ==========================================================
   // Configuration registers
   // ==========================================================
   // Writes outside idle are dropped so a running sweep stays coherent
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= 4'h0;
         fstart_r <= FREQ_RST;
         fstep_r <= FREQ_RST;
         npts_r <= NPTS_RST;
      end
      else if (wr && idle) // RULE5
      begin
         case (adr_i)
            {1'b0, ADDR_CTRL}: ctrl_r <= wdata[3:0];
            {1'b0, ADDR_FSTART}: fstart_r <= wdata; // RULE8
            {1'b0, ADDR_FSTEP}: fstep_r <= wdata;   // RULE8
            ADDR_NPTS: npts_r <= wdata[15:0];       // RULE8
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read path and acknowledge
   // ==========================================================
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         dat_r <= ZERO32;
      end
      else if (ce_i)
      begin
         ack_r <= req;
         if (req && !we_i)
         begin
            case (adr_i)
               {1'b0, ADDR_CTRL}: dat_r <= {28'h0000000, ctrl_r};
               {1'b0, ADDR_FSTART}: dat_r <= fstart_r;
               {1'b0, ADDR_FSTEP}: dat_r <= fstep_r;
               ADDR_NPTS: dat_r <= {16'h0000, npts_r};
               ADDR_STATUS: dat_r <= {29'h0000000, (state_r == ST_ARMED),
                                      !idle, (state_r == ST_SWEEP)}; // RULE9
               ADDR_FCUR: dat_r <= freq_r;
               default: dat_r <= ZERO32;
            endcase
         end
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;
   assign trig_out_o = (state_r == ST_SWEEP); // RULE3 RULE4
   assign freq_o = freq_r;
   assign sweeping_o = !idle; // RULE9
endmodule : sweep_trigger_control
`default_nettype wire

// ---- include/sweep_pkg.sv ----
package sweep_pkg;
   // ==========================================================
   // Register map (byte addresses, one word each)
   // ==========================================================
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CMD = 4'h4;
   localparam logic [3:0] ADDR_FSTART = 4'h8;
   localparam logic [3:0] ADDR_FSTEP = 4'hC;
   // Index 0 of the second bank lives above 4'hC, see widened decode
   localparam logic [4:0] ADDR_NPTS = 5'h10;
   localparam logic [4:0] ADDR_STATUS = 5'h14;
   localparam logic [4:0] ADDR_FCUR = 5'h18;
   localparam int ADDR_W = 5;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_MODE_LSB = 0;   // 2 bits: trigger source
   localparam int CTRL_FALL_BIT = 2;   // 1 = falling edge
   localparam int CTRL_NOHOLD_BIT = 3; // 1 = return to start after sweep
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int CMD_MANUAL_BIT = 2;
   localparam int ST_SWEEP_BIT = 0;
   localparam int ST_MODE_BIT = 1;
   localparam int ST_ARMED_BIT = 2;

   // ==========================================================
   // Reset values and encodings
   // ==========================================================
   localparam logic [31:0] FREQ_RST = 32'h0000_0000;
   localparam logic [15:0] NPTS_RST = 16'h0001;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      TRIG_FREE = 2'h0,
      TRIG_EXT = 2'h1,
      TRIG_MANUAL = 2'h2
   } trig_mode_t;

   // Gray along idle -> armed -> sweeping -> armed
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_SWEEP = 2'h3
   } sweep_state_t;
endpackage : sweep_pkg

// ---- testbench/sweep_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module sweep_checker
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic ce_i, // Enable
   input wire logic cyc_i, // Cycle
   input wire logic stb_i, // Strobe
   input wire logic we_i, // Write
   input wire logic [sweep_pkg::ADDR_W-1:0] adr_i, // Address
   input wire logic [3:0] sel_i, // Selects
   input wire logic [31:0] dat_i, // Write data
   input wire logic [31:0] dat_o, // Read data
   input wire logic ack_o, // Ack
   input wire logic trig_in_i, // Trigger in
   input wire logic point_done_i, // Point done
   input wire logic trig_out_o, // Trigger out
   input wire logic [31:0] freq_o, // Frequency
   input wire logic sweeping_o // Sweep mode
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic bus_w;
   // A taken write is the only way a command can reach the block
   assign bus_w = cyc_i && stb_i && we_i;
   AST_ACK_NEXT: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
      else $error("request not acked");
   AST_ACK_PULSE: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack too long");
   AST_RESET_QUIET: assert property ($past(rst_i) |-> !ack_o && !trig_out_o && !sweeping_o)
      else $error("busy after reset");
   AST_TRIG_IN_MODE: assert property (trig_out_o |-> sweeping_o)
      else $error("trigger out outside sweep mode");
   AST_ROSE_CMD: assert property ($rose(sweeping_o) |-> $past(bus_w))
      else $error("sweep mode without command");
   AST_RISE_ARMED: assert property ($rose(trig_out_o) |-> $past(sweeping_o))
      else $error("sweep began while idle");
   AST_FELL_CAUSE: assert property ($fell(trig_out_o) |-> $past(point_done_i) || $past(bus_w))
      else $error("sweep ended without cause");
   AST_STOP_FREEZE: assert property ($fell(sweeping_o) |-> $stable(freq_o))
      else $error("stop moved frequency");
   AST_ARMED_HOLD: assert property (sweeping_o && !trig_out_o && $past(sweeping_o && !trig_out_o)
      |-> $stable(freq_o))
      else $error("armed frequency moved");
   AST_SWEEP_STEP: assert property (trig_out_o && $past(trig_out_o) && !$past(point_done_i)
      |-> $stable(freq_o))
      else $error("frequency moved without point");
   COV_SWEEP: cover property ($rose(trig_out_o));
   COV_END: cover property ($fell(trig_out_o) && sweeping_o);
   COV_STOP: cover property ($fell(sweeping_o) && $past(trig_out_o));
endmodule : sweep_checker
bind sweep_trigger_control sweep_checker i_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
   .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .trig_in_i, .point_done_i, .trig_out_o, .freq_o,
   .sweeping_o);
`default_nettype wire

// ---- testbench/sweep_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Trigger source and measurement engine
module sweep_partner
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic fire_i, // Emit one trigger
   input wire logic fall_i, // Active low trigger
   input wire logic [3:0] gap_i, // Cycles per point minus one
   input wire logic trig_out_i, // Sweep running
   output logic trig_o, // Trigger line
   output logic done_o // Point measured
);
   logic [1:0] act_r;
   logic [3:0] cnt_r;
   // Two-cycle trigger so a slow sampler cannot miss it
   always_ff @(posedge clk_i)
   begin
      act_r <= rst_i ? 2'h0 : fire_i ? 2'h2 : (act_r == 2'h0 ? 2'h0 : act_r - 2'h1);
   end
   assign trig_o = fall_i ^ (act_r != 2'h0);
   // Measures only while a sweep runs, one point each gap_i+1 cycles
   always_ff @(posedge clk_i)
   begin
      cnt_r <= (rst_i || !trig_out_i || done_o) ? 4'h0 : cnt_r + 4'h1;
   end
   assign done_o = trig_out_i && (cnt_r == gap_i);
endmodule : sweep_partner
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Testbench
module tb;
   import sweep_pkg::*;
   localparam logic [4:0] A_CMD = {1'b0, ADDR_CMD};
   localparam logic [31:0] F0 = 32'h0000_1000;
   localparam logic [31:0] ST = 32'h0000_0040;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, freq_o, q;
   logic ack_o, trig_in_i, point_done_i, trig_out_o, sweeping_o;
   logic fire_r = 1'b0, fall_r = 1'b0;
   logic [3:0] gap_r = 4'h7;
   int mismatches = 0, checks = 0;
   always #10 clk_i = ~clk_i;
   sweep_trigger_control i_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .trig_in_i, .point_done_i, .trig_out_o, .freq_o, .sweeping_o);
   sweep_partner i_far (.clk_i, .rst_i, .fire_i(fire_r), .fall_i(fall_r), .gap_i(gap_r),
      .trig_out_i(trig_out_o), .trig_o(trig_in_i), .done_o(point_done_i));
   task chk(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   // Classic cycle; the request stands until ack is sampled
   task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1)
      begin
         mismatches++;
         $display("MISMATCH %0t no ack", $time);
      end
      q = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task wait_for(input logic l);
      int n;
      n = 0;
      while (trig_out_o !== l && n < 300) begin @(posedge clk_i); n++; end
      chk({31'h0, l}, {31'h0, trig_out_o});
   endtask : wait_for
   task fire();
      fire_r <= 1'b1; @(posedge clk_i); fire_r <= 1'b0; @(posedge clk_i);
   endtask : fire
   task prog(input logic [31:0] c);
      wb(1'b1, {1'b0, ADDR_FSTART}, F0); wb(1'b1, {1'b0, ADDR_FSTEP}, ST);
      wb(1'b1, ADDR_NPTS, 32'h3); wb(1'b1, {1'b0, ADDR_CTRL}, c); wb(1'b1, A_CMD, 32'h1);
   endtask : prog
   task stop();
      wb(1'b1, A_CMD, 32'h2); wb(1'b0, ADDR_STATUS, 0); chk(32'h0, q);
   endtask : stop
   task s_regs();
      wb(1'b0, ADDR_NPTS, 0); chk({16'h0, NPTS_RST}, q);
      wb(1'b0, 5'h1C, 0); chk(ZERO32, q);
   endtask : s_regs
   task s_free();
      int n;
      prog(32'h0); wait_for(1'b1); chk(F0, freq_o);
      wb(1'b1, {1'b0, ADDR_FSTART}, 32'h0);
      n = 0;
      while (freq_o === F0 && n < 40) begin @(posedge clk_i); n++; end
      // Enable low for two whole point periods: finished points must be ignored
      ce_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      chk(F0 + ST, freq_o);
      ce_i <= 1'b1;
      stop(); chk(F0 + ST, freq_o);
      wb(1'b0, ADDR_FCUR, 0); chk(F0 + ST, q);
      wb(1'b0, {1'b0, ADDR_FSTART}, 0); chk(F0, q);
   endtask : s_free
   task s_ext();
      prog(32'h1); wb(1'b0, ADDR_STATUS, 0); chk(32'h6, q);
      repeat (20) @(posedge clk_i);
      chk(32'h0, {31'h0, trig_out_o});
      fire(); wait_for(1'b1); chk(F0, freq_o);
      // Second trigger lands after the first point, so a restart would show
      repeat (12) @(posedge clk_i);
      fire(); @(posedge clk_i); chk(F0 + ST, freq_o);
      wait_for(1'b0);
      repeat (10) @(posedge clk_i);
      chk(F0 + ST + ST, freq_o);
      stop();
   endtask : s_ext
   task s_fall();
      fall_r <= 1'b1;
      prog(32'hD); fire(); wait_for(1'b1); wait_for(1'b0); chk(F0, freq_o);
      stop(); fall_r <= 1'b0;
   endtask : s_fall
   task s_man();
      gap_r <= 4'h1;
      prog(32'h2); fire();
      repeat (10) @(posedge clk_i);
      chk(32'h0, {31'h0, trig_out_o});
      wb(1'b1, A_CMD, 32'h4); wait_for(1'b1); wait_for(1'b0);
      chk(F0 + ST + ST, freq_o); stop();
   endtask : s_man
   task give_verdict();
      if (mismatches == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      s_regs(); s_free(); s_ext(); s_fall(); s_man();
      give_verdict();
   end
   // Whole run is under a thousand cycles
   initial
   begin
      #100000;
      mismatches++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
